//--- ssbp_defs.svh
// Purpose: constants for the synchronous burst sram port
// Assumes: a single 200 MHz core clock and a synchronous reset
// Notes: definitions only
//
// Notes on behaviour
// - expansion_select_high is active high, sampled at the edge, part of selection.
// - expansion_select_low_n is active low, sampled at the edge, part of selection.
// - chip selects are looked at only when an address strobe loads an address.
// - data pins drive while output enable is low, float while it is high.
// - output enable is ignored in the first read clock after deselect.
// - burst_step_n low at an edge during a burst advances the burst address.
// - processor strobe low captures the address and loads bits [1:0] into the counter.
// - controller strobe low captures the address and loads bits [1:0] into the counter.
// - with both strobes low only the processor strobe is acted on.
// - processor strobe is ignored while primary_select_n is high.
// - sleep_request high gives a quiet state that keeps contents; low means normal.
// - write data on the data pins is captured into a data register at the edge.
// - reads return the location addressed at the previous rising edge.
// - data and parity float during writes, first clock after deselect, and deselected.
// - parity pins behave like data, each written with its own byte lane.
// - burst-order strap low gives linear, high gives interleaved; it must not change.
// - all_lanes_write_n low writes every lane regardless of other write inputs.
// - a lane is written when its lane select and the byte-write gate are low.
// - primary_select_n is active low, sampled at the edge, part of selection.
// - the burst counter is two bits and wraps over four locations.
`ifndef SSBP_DEFS_SVH
`define SSBP_DEFS_SVH

`define SSBP_ADDR_W      18
`define SSBP_DATA_W      32
`define SSBP_LANES       4
`define SSBP_LANE_W      8
`define SSBP_FIFO_DEPTH  16
`define SSBP_ENTRY_W     58
`define SSBP_BURST_W     2
`define SSBP_STRAP_INTLV 1'b1

`endif

//--- ssbp_fifo.sv
// Purpose: write buffer between the pin capture and the storage array
// Assumes: DEPTH is a power of two
// Notes: full and empty come from pointers with one extra wrap bit
`timescale 1ns/10ps
`default_nettype none
module ssbp_fifo
	import ssbp_pkg::*;
#(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// buffer ports
	ssbp_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] store [DEPTH];
	logic [AW:0]  wr_ptr_ff;
	logic [AW:0]  rd_ptr_ff;
	wire          empty;
	wire          full;
	wire          do_push;
	wire          do_pop;

	assign empty      = (wr_ptr_ff == rd_ptr_ff);
	assign full       = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	assign f.push_ready = !full;
	assign f.pop_valid  = !empty;
	assign f.pop_data   = store[rd_ptr_ff[AW-1:0]];
	assign do_push    = f.push_valid && !full;
	assign do_pop     = f.pop_ready && !empty;

	always_ff @(posedge core_clk) begin
		if (do_push) begin
			store[wr_ptr_ff[AW-1:0]] <= f.push_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + (AW+1)'(do_push);
			rd_ptr_ff <= rd_ptr_ff + (AW+1)'(do_pop);
		end
	end
endmodule
`default_nettype wire

//--- ssbp_fifo_if.sv
// Purpose: valid/ready carrier between the port and its write buffer
// Assumes: one clock domain
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface ssbp_fifo_if #(parameter int W = 8);
	logic         push_valid;
	logic         push_ready;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;

	modport fifo (input push_valid, input push_data, output push_ready,
		output pop_valid, output pop_data, input pop_ready);
	modport user (output push_valid, output push_data, input push_ready,
		input pop_valid, input pop_data, output pop_ready);
endinterface
`default_nettype wire

//--- ssbp_host_model.sv
// Purpose: bus-side controller model driving the pins of the burst sram port
// Assumes: cyc is entered 1 ns after a rising edge
// Notes: an undriven data wire shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
`include "ssbp_defs.svh"
module ssbp_host_model (
	// clock
	input  wire logic                    core_clk,
	// selection, strobes and address
	output logic                         primary_select_n,
	output logic                         expansion_select_high,
	output logic                         expansion_select_low_n,
	output logic                         processor_addr_strobe_n,
	output logic                         controller_addr_strobe_n,
	output logic                         burst_step_n,
	output logic [`SSBP_ADDR_W-1:0]      addr_in,
	// write controls
	output logic                         byte_write_gate_n,
	output logic [`SSBP_LANES-1:0]       lane_write_select_n,
	output logic                         all_lanes_write_n,
	// resolved pin levels
	output logic [`SSBP_DATA_W-1:0]      dq_in,
	output logic [`SSBP_LANES-1:0]       parity_pins_in,
	input  wire logic [`SSBP_DATA_W-1:0] dq_out,
	input  wire logic                    dq_oe,
	input  wire logic [`SSBP_LANES-1:0]  parity_pins_out,
	input  wire logic                    parity_pins_oe
);
	// ********************************
	// pin drive
	// ********************************
	logic        drv = 1'b0;
	logic [35:0] wd  = 36'h0;
	logic [35:0] lq  = 36'h0;

	assign dq_in          = dq_oe ? dq_out : drv ? wd[31:0] : ~lq[31:0];
	assign parity_pins_in = parity_pins_oe ? parity_pins_out : drv ? wd[35:32] : ~lq[35:32];
	always @(posedge core_clk) lq <= {parity_pins_in, dq_in};

	initial begin
		{primary_select_n, expansion_select_high, expansion_select_low_n} = 3'b010;
		{processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n} = 3'b111;
		addr_in = '0;
		{all_lanes_write_n, byte_write_gate_n, lane_write_select_n} = 6'h3f;
	end

	task automatic cyc(input logic [2:0] s, input logic ps, input logic cs, input logic st,
		input logic [`SSBP_ADDR_W-1:0] a, input logic [5:0] w, input logic [35:0] d);
		{primary_select_n, expansion_select_high, expansion_select_low_n} = s;
		processor_addr_strobe_n = ps;
		controller_addr_strobe_n = cs;
		burst_step_n = st;
		addr_in = a;
		{all_lanes_write_n, byte_write_gate_n, lane_write_select_n} = w;
		wd = d;
		drv = !(&w[5:4]);
		@(posedge core_clk);
		#1;
	endtask
endmodule
`default_nettype wire

//--- ssbp_pkg.sv
// Purpose: shared types of the burst sram port
// Assumes: ssbp_defs.svh supplies the widths
// Notes: none
`include "ssbp_defs.svh"
package ssbp_pkg;

	// cycle state of the port
	typedef enum logic [1:0] {
		SSBP_ST_IDLE  = 2'b00,
		SSBP_ST_READ  = 2'b01,
		SSBP_ST_WRITE = 2'b10
	} ssbp_state_t;

	typedef enum logic {
		SSBP_ORD_LINEAR = 1'b0,
		SSBP_ORD_INTLV  = 1'b1
	} ssbp_order_t;

	// one buffered write: address, lane mask, parity, data
	typedef struct packed {
		logic [`SSBP_ADDR_W-1:0] addr;
		logic [`SSBP_LANES-1:0]  lanes;
		logic [`SSBP_LANES-1:0]  par;
		logic [`SSBP_DATA_W-1:0] data;
	} ssbp_entry_t;

endpackage

//--- ssbp_top.sv
// Purpose: pin-level control of a flow-through burst sram port with storage
// Assumes: all pin inputs synchronous to core_clk, strap stable in operation
// Notes: writes pass through a 16-word buffer before reaching the array
`timescale 1ns/10ps
`default_nettype none
`include "ssbp_defs.svh"
module ssbp_top
	import ssbp_pkg::*;
(
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	// selection and strobes
	input  wire logic                     primary_select_n,
	input  wire logic                     expansion_select_high,
	input  wire logic                     expansion_select_low_n,
	input  wire logic                     processor_addr_strobe_n,
	input  wire logic                     controller_addr_strobe_n,
	input  wire logic                     burst_step_n,
	input  wire logic [`SSBP_ADDR_W-1:0]  addr_in,
	// write controls
	input  wire logic                     byte_write_gate_n,
	input  wire logic [`SSBP_LANES-1:0]   lane_write_select_n,
	input  wire logic                     all_lanes_write_n,
	// output enable, sleep and strap
	input  wire logic                     out_enable_n,
	input  wire logic                     sleep_request,
	input  wire logic                     burst_order_strap,
	// data pins
	input  wire logic [`SSBP_DATA_W-1:0]  dq_in,
	output logic      [`SSBP_DATA_W-1:0]  dq_out,
	output logic                          dq_oe,
	// parity pins
	input  wire logic [`SSBP_LANES-1:0]   parity_pins_in,
	output logic      [`SSBP_LANES-1:0]   parity_pins_out,
	output logic                          parity_pins_oe,
	// write buffer status
	output logic                          wr_buf_ready
);
	// ****************************************
	// burst address arithmetic
	// ****************************************
	function automatic logic [1:0] burst_low(input ssbp_order_t ord, input logic [1:0] start,
		input logic [1:0] step);
		burst_low = (ord == SSBP_ORD_INTLV) ? (start ^ step) : (start + step);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [`SSBP_DATA_W+`SSBP_LANES-1:0] mem [2**`SSBP_ADDR_W];
	ssbp_state_t                  cyc_ff;
	ssbp_state_t                  nxt_cyc;
	ssbp_order_t                  order_ff;
	logic                         first_ff;
	logic [`SSBP_ADDR_W-1:0]      base_ff;
	logic [1:0]                   step_ff;
	logic [1:0]                   nxt_step;
	logic [`SSBP_ADDR_W-1:0]      nxt_base;
	logic                         wr_pend_ff;
	ssbp_entry_t                  wr_entry_ff;
	logic [`SSBP_DATA_W-1:0]      rd_data_ff;
	logic [`SSBP_LANES-1:0]       rd_par_ff;

	ssbp_fifo_if #(.W(`SSBP_ENTRY_W)) wbuf ();

	// ****************************************
	// decode
	// ****************************************
	wire                     selected;
	wire                     load_p;
	wire                     load_c;
	wire                     load;
	wire                     active;
	wire                     advance;
	wire [`SSBP_LANES-1:0]   lane_mask;
	wire                     wr_any;
	wire                     wr_take;
	wire [`SSBP_ADDR_W-1:0]  cur_addr;
	wire [`SSBP_ADDR_W-1:0]  nxt_addr;
	wire [`SSBP_ADDR_W-1:0]  wr_addr;
	wire                     pins_drive;
	ssbp_entry_t             drain;

	assign selected  = !primary_select_n && expansion_select_high && !expansion_select_low_n;
	assign load_p    = !sleep_request && !processor_addr_strobe_n && !primary_select_n;
	assign load_c    = !sleep_request && !controller_addr_strobe_n && !load_p;
	assign load      = load_p || load_c;
	assign active    = (cyc_ff != SSBP_ST_IDLE);
	assign advance   = !sleep_request && !load && active && !burst_step_n;
	assign lane_mask = !all_lanes_write_n ? {`SSBP_LANES{1'b1}} :
		(!byte_write_gate_n ? ~lane_write_select_n : {`SSBP_LANES{1'b0}});
	assign wr_any    = |lane_mask;
	// processor-strobe load cycles ignore the write inputs
	assign wr_take   = !sleep_request && wr_any && !load_p &&
		((load_c && selected) || (!load && active));
	assign cur_addr  = {base_ff[`SSBP_ADDR_W-1:2], burst_low(order_ff, base_ff[1:0], step_ff)};
	assign wr_addr   = load_c ? addr_in : cur_addr;

	always_comb begin
		nxt_base = base_ff;
		nxt_step = step_ff;
		nxt_cyc  = cyc_ff;
		if (load) begin
			nxt_cyc = SSBP_ST_IDLE;
			if (selected) begin
				nxt_base = addr_in;
				nxt_step = 2'h0;
				nxt_cyc  = wr_take ? SSBP_ST_WRITE : SSBP_ST_READ;
			end
		end else if (!sleep_request && active) begin
			nxt_cyc = wr_take ? SSBP_ST_WRITE : SSBP_ST_READ;
			if (advance) begin
				nxt_step = step_ff + 2'h1;
			end
		end
	end

	assign nxt_addr = {nxt_base[`SSBP_ADDR_W-1:2], burst_low(order_ff, nxt_base[1:0], nxt_step)};

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cyc_ff   <= SSBP_ST_IDLE;
			first_ff <= 1'b0;
			base_ff  <= '0;
			step_ff  <= 2'h0;
			order_ff <= SSBP_ORD_INTLV;
		end else begin
			cyc_ff   <= nxt_cyc;
			first_ff <= (cyc_ff == SSBP_ST_IDLE) && (nxt_cyc == SSBP_ST_READ);
			base_ff  <= nxt_base;
			step_ff  <= nxt_step;
			order_ff <= ssbp_order_t'(burst_order_strap == `SSBP_STRAP_INTLV);
		end
	end

	// write data register feeding the buffer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_pend_ff  <= 1'b0;
			wr_entry_ff <= '0;
		end else begin
			wr_pend_ff <= wr_take;
			if (wr_take) begin
				wr_entry_ff <= '{addr: wr_addr, lanes: lane_mask,
					par: parity_pins_in, data: dq_in};
			end
		end
	end

	// flow-through read of the address loaded at this edge
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_data_ff <= '0;
			rd_par_ff  <= '0;
		end else begin
			{rd_par_ff, rd_data_ff} <= mem[nxt_addr];
		end
	end

	// ****************************************
	// write buffer and array update
	// ****************************************
	assign wbuf.push_valid = wr_pend_ff;
	assign wbuf.push_data  = wr_entry_ff;
	assign wbuf.pop_ready  = !sleep_request;
	assign wr_buf_ready    = wbuf.push_ready;
	assign drain           = wbuf.pop_data;

	ssbp_fifo #(
		.W     (`SSBP_ENTRY_W),
		.DEPTH (`SSBP_FIFO_DEPTH)
	) u_wbuf (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.f        (wbuf.fifo)
	);

	always_ff @(posedge core_clk) begin
		if (wbuf.pop_valid && wbuf.pop_ready) begin
			for (int i = 0; i < `SSBP_LANES; i++) begin
				if (drain.lanes[i]) begin
					mem[drain.addr][i*`SSBP_LANE_W +: `SSBP_LANE_W] <= drain.data[i*`SSBP_LANE_W +: `SSBP_LANE_W];
					mem[drain.addr][`SSBP_DATA_W+i] <= drain.par[i];
				end
			end
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	assign pins_drive = !out_enable_n && (cyc_ff == SSBP_ST_READ) && !first_ff &&
		!sleep_request && !(wr_any && active);
	assign dq_oe           = pins_drive;
	assign parity_pins_oe  = pins_drive;
	assign dq_out          = rd_data_ff;
	assign parity_pins_out = rd_par_ff;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_idle_to_read;
		(cyc_ff == SSBP_ST_IDLE) ##1 (cyc_ff == SSBP_ST_READ);
	endsequence
	sequence s_step_cond;
		active && !load && !sleep_request && !burst_step_n;
	endsequence

	AST_FIRST_FLOAT: assert property (s_idle_to_read |-> !dq_oe)
		else $error("pins driven in first read clock after deselect");
	AST_DESEL_FLOAT: assert property ((cyc_ff == SSBP_ST_IDLE) |-> !dq_oe && !parity_pins_oe)
		else $error("pins driven while deselected");
	AST_OE_FLOAT: assert property (out_enable_n |-> !dq_oe)
		else $error("pins driven while output enable high");
	AST_READ_DRIVE: assert property (s_idle_to_read ##1 (cyc_ff == SSBP_ST_READ && !out_enable_n
		&& !sleep_request && !wr_any) |-> dq_oe)
		else $error("second read clock not driven");
	AST_PRIO: assert property (load_p && !controller_addr_strobe_n && selected |=> cyc_ff == SSBP_ST_READ)
		else $error("controller strobe acted on beside processor strobe");
	AST_CE1_IGN: assert property (!processor_addr_strobe_n && primary_select_n && controller_addr_strobe_n
		&& !active |=> cyc_ff == SSBP_ST_IDLE)
		else $error("processor strobe taken with primary select high");
	AST_STEP: assert property (s_step_cond |=> step_ff == $past(step_ff) + 2'h1)
		else $error("burst counter did not advance");
	AST_HOLD: assert property (burst_step_n && processor_addr_strobe_n && controller_addr_strobe_n
		|=> $stable(step_ff) && $stable(base_ff))
		else $error("burst address moved without step or strobe");
	AST_LOAD: assert property (load && selected |=> step_ff == 2'h0 && base_ff[1:0] == $past(addr_in[1:0]))
		else $error("strobe did not load counter");
	AST_SLEEP: assert property (sleep_request |-> !dq_oe ##1 $stable(base_ff))
		else $error("activity during sleep");
	AST_WRAP: assert property (s_step_cond and step_ff == 2'h3 |=> step_ff == 2'h0)
		else $error("burst counter did not wrap");
endmodule
`default_nettype wire

//--- ssbp_top_test.sv
// Purpose: self-checking bench of the burst sram port
// Assumes: pins move 1 ns after the rising edge
// Notes: expected words come from a shadow of written data
`timescale 1ns/10ps
`default_nettype none
`include "ssbp_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e) || $isunknown(g)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module ssbp_top_test;
	import ssbp_pkg::*;
	// ********************************
	// bench state and instances
	// ********************************
	localparam logic [2:0] SEL = 3'b010;
	localparam logic [5:0] NOW = 6'h3f;
	localparam logic [5:0] ALL = 6'h1f;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic out_enable_n = 1'b1;
	logic sleep_request = 1'b0;
	logic burst_order_strap = 1'b1;
	logic primary_select_n, expansion_select_high, expansion_select_low_n, processor_addr_strobe_n;
	logic controller_addr_strobe_n, burst_step_n, byte_write_gate_n, all_lanes_write_n, dq_oe;
	logic parity_pins_oe, wr_buf_ready;
	logic [`SSBP_ADDR_W-1:0] addr_in;
	logic [3:0] lane_write_select_n, parity_pins_in, parity_pins_out;
	logic [31:0] dq_in, dq_out;
	logic [35:0] sh [0:63];
	int n_fail = 0;
	int checks = 0;

	always #2.5 core_clk = ~core_clk;

	ssbp_top ssbp_top_i (.core_clk, .sys_rst, .primary_select_n, .expansion_select_high, .expansion_select_low_n,
		.processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n, .addr_in, .byte_write_gate_n,
		.lane_write_select_n, .all_lanes_write_n, .out_enable_n, .sleep_request, .burst_order_strap, .dq_in,
		.dq_out, .dq_oe, .parity_pins_in, .parity_pins_out, .parity_pins_oe, .wr_buf_ready);
	ssbp_host_model ssbp_host_model_i (.core_clk, .primary_select_n, .expansion_select_high,
		.expansion_select_low_n, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n, .addr_in,
		.byte_write_gate_n, .lane_write_select_n, .all_lanes_write_n, .dq_in, .parity_pins_in, .dq_out, .dq_oe,
		.parity_pins_out, .parity_pins_oe);

	// ********************************
	// shared tasks
	// ********************************
	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cyc(input logic [2:0] s, input logic ps, input logic cs, input logic st,
		input logic [17:0] a, input logic [5:0] w, input logic [35:0] d);
		ssbp_host_model_i.cyc(s, ps, cs, st, a, w, d);
	endtask

	task automatic rst();
		sys_rst = 1'b1;
		repeat (16) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		out_enable_n = 1'b0;
		`CHK({dq_oe, wr_buf_ready, dq_out}, {2'b01, 32'h0})
	endtask

	task automatic wr_word(input logic [17:0] a, input logic [5:0] w, input logic [35:0] d);
		logic [3:0] m;
		m = !w[5] ? 4'hf : !w[4] ? ~w[3:0] : 4'h0;
		cyc(SEL, 1'b0, 1'b1, 1'b1, a, NOW, 36'h0);
		cyc(SEL, 1'b1, 1'b1, 1'b1, a, w, d);
		`CHK(dq_oe, m == 4'h0)
		for (int i = 0; i < 4; i++) begin
			if (m[i]) begin
				sh[a[5:0]][8*i+:8] = d[8*i+:8];
				sh[a[5:0]][32+i] = d[32+i];
			end
		end
	endtask

	task automatic fill();
		for (int k = 0; k < 4; k++)
			wr_word(18'h10 + 18'(k), ALL, {4'(k), 26'h2b5a3c0, 6'(k)});
	endtask

	task automatic drain();
		cyc(3'b000, 1'b0, 1'b1, 1'b1, 18'h0, NOW, 36'h0);
		repeat (20) begin
			cyc(SEL, 1'b1, 1'b1, 1'b1, 18'h0, NOW, 36'h0);
			`CHK(dq_oe, 1'b0)
		end
	endtask

	task automatic rd(input logic [17:0] a, input logic pr);
		logic [1:0] lo;
		cyc(SEL, !pr, pr, 1'b1, a, NOW, 36'h0);
		`CHK(dq_oe, 1'b0)
		`CHK({parity_pins_out, dq_out}, sh[a[5:0]])
		for (int k = 1; k < 4; k++) begin
			lo = burst_order_strap ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
			cyc(SEL, 1'b1, 1'b1, 1'b0, a, NOW, 36'h0);
			`CHK(dq_oe, 1'b1)
			`CHK({parity_pins_out, dq_out}, sh[{a[5:2], lo}])
		end
		out_enable_n = 1'b1;
		#1;
		`CHK({dq_oe, parity_pins_oe}, 2'b00)
		out_enable_n = 1'b0;
		@(posedge core_clk);
		#1;
	endtask

	// ********************************
	// scenarios
	// ********************************
	task automatic t_lanes();
		// the burst read-back below also visits the three neighbours of 0x20
		for (int k = 1; k < 4; k++)
			wr_word(18'h20 + 18'(k), ALL, {4'(k), 32'h0c3a5e00 + 32'(k)});
		wr_word(18'h20, ALL, 36'ha11223344);
		wr_word(18'h20, 6'h2a, 36'h5aabbccdd);
		wr_word(18'h20, 6'h30, 36'hfffffffff);
		drain();
		rd(18'h20, 1'b1);
		$display("t_lanes done");
	endtask

	task automatic t_strobes();
		logic [2:0] bad [3] = '{3'b000, 3'b011, 3'b110};
		cyc(SEL, 1'b0, 1'b1, 1'b1, 18'h13, NOW, 36'h0);
		cyc(3'b110, 1'b0, 1'b1, 1'b1, 18'h20, NOW, 36'h0);
		`CHK({dq_oe, parity_pins_out, dq_out}, {1'b1, sh[6'h13]})
		cyc(SEL, 1'b0, 1'b0, 1'b1, 18'h10, ALL, 36'h0);
		`CHK({parity_pins_out, dq_out}, sh[6'h10])
		cyc(3'b000, 1'b1, 1'b1, 1'b0, 18'h20, NOW, 36'h0);
		`CHK({dq_oe, parity_pins_out, dq_out}, {1'b1, sh[6'h11]})
		foreach (bad[i]) begin
			cyc(bad[i], 1'b1, 1'b0, 1'b1, 18'h10, NOW, 36'h0);
			cyc(SEL, 1'b1, 1'b1, 1'b1, 18'h10, NOW, 36'h0);
			`CHK(dq_oe, 1'b0)
		end
		drain();
		rd(18'h10, 1'b1);
		$display("t_strobes done");
	endtask

	task automatic t_sleep();
		cyc(SEL, 1'b0, 1'b1, 1'b1, 18'h10, NOW, 36'h0);
		cyc(SEL, 1'b1, 1'b1, 1'b0, 18'h10, NOW, 36'h0);
		sleep_request = 1'b1;
		repeat (2) begin
			cyc(SEL, 1'b1, 1'b1, 1'b0, 18'h10, NOW, 36'h0);
			`CHK(dq_oe, 1'b0)
		end
		sleep_request = 1'b0;
		cyc(SEL, 1'b1, 1'b1, 1'b0, 18'h10, NOW, 36'h0);
		`CHK({parity_pins_out, dq_out}, sh[6'h12])
		$display("t_sleep done");
	endtask

	initial begin
		#100000;
		n_fail++;
		end_sim();
	end

	initial begin
		rst();
		fill();
		drain();
		rd(18'h11, 1'b1);
		$display("t_intlv done");
		t_lanes();
		t_strobes();
		t_sleep();
		burst_order_strap = 1'b0;
		rst();
		fill();
		drain();
		rd(18'h12, 1'b0);
		$display("t_lin done");
		end_sim();
	end
endmodule
`default_nettype wire
